// file: src/snv_pkg.sv
package snv_pkg;
    // ==========================================
    // Command op-codes
    localparam logic [7:0] OP_LATCH_SET    = 8'h06; // latch_set_cmd
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04; // latch_clear_cmd
    localparam logic [7:0] OP_STATUS_READ  = 8'h05; // status_read_cmd
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status_write_cmd
    localparam logic [7:0] OP_MEM_READ     = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE    = 8'h02;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9F; // identity_read_cmd
    // ==========================================
    // Array geometry
    localparam int         ADDR_W     = 11;
    localparam int         DATA_W     = 8;
    localparam int         DEPTH      = 2048;
    localparam logic [10:0] ADDR_TOP  = 11'h7FF;
    localparam logic [10:0] ADDR_ZERO = 11'h000;
    localparam logic [10:0] QUART_BASE = 11'h600; // Upper quarter start
    localparam logic [10:0] HALF_BASE  = 11'h400; // Upper half start
    // ==========================================
    // Status byte bit positions
    localparam int ST_PROT_EN = 7;
    localparam int ST_SPARE_HI = 6;
    localparam int ST_SPARE_LO = 4;
    localparam int ST_BP_HIGH = 3;
    localparam int ST_BP_LOW  = 2;
    localparam int ST_LATCH   = 1;
    localparam logic [7:0] ST_NV_MASK = 8'hFC; // Writable nonvolatile bits
    localparam logic [7:0] ST_RESET   = 8'h00;
    // ==========================================
    // Bit counts
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [4:0] ID_LAST   = 5'h1F;
    localparam logic [1:0] ADDR_BYTES = 2'h2;
    // Identity value, arbitrary, names no maker
    localparam logic [31:0] ID_WORD = 32'h5A_7F_12_35;
    // ==========================================
    // Command state
    typedef enum logic [2:0] {
        SNV_OPCODE = 3'b000,
        SNV_ADDR   = 3'b001,
        SNV_SREAD  = 3'b010,
        SNV_SWRITE = 3'b011,
        SNV_MREAD  = 3'b100,
        SNV_MWRITE = 3'b101,
        SNV_IDENT  = 3'b110,
        SNV_IDLE   = 3'b111
    } snv_state_t;
endpackage : snv_pkg

// file: src/snv_mem.sv
// ==========================================
// Array storage, registered read port
module snv_mem (
    input  wire logic                      mclk,
    input  wire logic                      we,
    input  wire logic [snv_pkg::ADDR_W-1:0] waddr,
    input  wire logic [snv_pkg::DATA_W-1:0] wdata,
    input  wire logic [snv_pkg::ADDR_W-1:0] raddr,
    output logic      [snv_pkg::DATA_W-1:0] rdata
);
    // Storage, contents survive reset like the real array
    logic [snv_pkg::DATA_W-1:0] mem [snv_pkg::DEPTH];

    // Write port
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port always registered
    always_ff @(posedge mclk) begin
        rdata <= mem[raddr];
    end
endmodule // snv_mem

// file: src/snv_core.sv
// Function
// - First eight bits form the op-code
// - Partial op-code at deselect is dropped
// - Latch-set op-code sets write latch
// - Latch-clear op-code clears; clear latch blocks writes
// - Status read shifts status on falling edges
// - Status byte repeats while clocks continue
// - Status write stores eight following bits
// - Status bits one and zero not writable
// - Memory read ignores top five address bits
// - Memory read increments and wraps address
// - Memory write stores each complete byte
// - Further write bytes go to next address
// - Identity read sends fixed 32-bit word
// - Last identity bit held until deselect
// - Block-protect bits select protected range
// - Latch gates all writes; range gates array writes; pin (with bit 7) gates status writes
// - Hold pauses command, ignores clock, floats output
// - Hold entry at any clock level; exit waits for that level again
// - Deselect during hold aborts command
// - Deselected device floats output, ignores inputs
// - Sample input rising, change output falling
// - Latch clears at reset, clear, write end
// - Status byte field layout
module snv_core (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic cs_n,      // Chip select pin, active low
    input  wire logic sck,       // Serial clock pin
    input  wire logic sdi,       // Serial data in pin
    input  wire logic hold_n,    // Hold pin, active low
    input  wire logic wp_n,      // Write-protect pin, active low
    output logic      sdo,       // Serial data out
    output logic      sdo_oe,    // High while driving serial out
    output logic      write_enable_latch // Latch state
);
    // ==========================================
    // Input synchronisers
    logic [4:0] sy1_reg;        // First stage, read only by second
    logic [4:0] sy2_reg;        // Second stage
    logic       sck_d_reg;      // Previous synced clock
    logic       cs_d_reg;       // Previous synced select
    logic       hold_act_reg;   // Hold in force
    logic       hold_lvl_reg;   // Clock level at hold entry

    // Two flops before any logic
    always_ff @(posedge mclk) begin
        if (rst) begin
            sy1_reg <= 5'h1C; // Idle pin levels, clock low, no false edge
            sy2_reg <= 5'h1C;
        end else begin
            sy1_reg <= {cs_n, hold_n, wp_n, sck, sdi};
            sy2_reg <= sy1_reg;
        end
    end

    wire cs_s   = sy2_reg[4];
    wire hold_s = sy2_reg[3];
    wire wp_s   = sy2_reg[2];
    wire sck_s  = sy2_reg[1];
    wire sdi_s  = sy2_reg[0];

    // Edge detection history
    always_ff @(posedge mclk) begin
        if (rst) begin
            sck_d_reg <= 1'b0;
            cs_d_reg  <= 1'b1;
        end else begin
            sck_d_reg <= sck_s;
            cs_d_reg  <= cs_s;
        end
    end

    wire cs_rise = cs_s & ~cs_d_reg;
    wire sel     = ~cs_s;
    // Hold ends only when clock back at entry level
    wire hold_exit = hold_act_reg & hold_s & (sck_s == hold_lvl_reg);

    // ==========================================
    // Hold tracking
    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            hold_act_reg <= 1'b0;
            hold_lvl_reg <= 1'b0;
        end else if (!hold_act_reg && !hold_s) begin
            hold_act_reg <= 1'b1;
            hold_lvl_reg <= sck_s;
        end else if (hold_exit) begin
            hold_act_reg <= 1'b0;
        end
    end

    // Edges count only when selected and not paused
    wire live    = sel & ~hold_act_reg & hold_s;
    wire sck_up  = live & sck_s & ~sck_d_reg;
    wire sck_dn  = live & ~sck_s & sck_d_reg;

    // ==========================================
    // Command state
    snv_pkg::snv_state_t state_reg;
    logic [2:0]  bit_reg;       // Bit within byte
    logic [7:0]  shin_reg;      // Input shifter
    logic [1:0]  abyte_reg;     // Address bytes taken
    logic [10:0] addr_reg;      // Array pointer
    logic [7:0]  op_reg;        // Recognised op-code
    logic [7:0]  shout_reg;     // Output shifter
    logic [4:0]  idc_reg;       // Identity bit count
    logic        wr_cmd_reg;    // Write-type command recognised
    logic [7:0]  stat_nv_reg;   // Nonvolatile status bits
    logic        mem_we_reg;    // Array write strobe
    logic [7:0]  mem_wd_reg;    // Array write data
    logic [10:0] mem_wa_reg;    // Array write address
    logic [7:0]  mem_rd;        // Array read data
    logic        byte_hold_gap; // Output held off until first data fall

    wire [7:0] next_in = {shin_reg[6:0], sdi_s};
    wire       byte_done = sck_up & (bit_reg == snv_pkg::BIT_LAST);
    // Status byte as seen by software
    wire [7:0] status_byte = (stat_nv_reg & snv_pkg::ST_NV_MASK) | {6'h00, write_enable_latch, 1'b0};

    // Block-protect range decode
    logic prot_hit;
    always_comb begin
        case ({stat_nv_reg[snv_pkg::ST_BP_HIGH], stat_nv_reg[snv_pkg::ST_BP_LOW]})
            2'h0:    prot_hit = 1'b0;
            2'h1:    prot_hit = addr_reg >= snv_pkg::QUART_BASE;
            2'h2:    prot_hit = addr_reg >= snv_pkg::HALF_BASE;
            default: prot_hit = 1'b1;
        endcase
    end

    wire mem_ok  = write_enable_latch & ~prot_hit;
    wire stat_ok = write_enable_latch & ~(stat_nv_reg[snv_pkg::ST_PROT_EN] & ~wp_s);

    // Array instance
    snv_mem u_mem (
        .mclk  (mclk),
        .we    (mem_we_reg),
        .waddr (mem_wa_reg),
        .wdata (mem_wd_reg),
        .raddr (addr_reg),
        .rdata (mem_rd)
    );

    // ==========================================
    // Bit counter and input shifter
    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            bit_reg  <= 3'h0;
            shin_reg <= 8'h00;
        end else if (sck_up) begin
            bit_reg  <= bit_reg + 3'h1;
            shin_reg <= next_in;
        end
    end

    // ==========================================
    // Command sequencer
    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            state_reg <= snv_pkg::SNV_OPCODE;
            abyte_reg <= 2'h0;
            op_reg    <= 8'h00;
        end else if (byte_done) begin
            case (state_reg)
                snv_pkg::SNV_OPCODE: begin
                    op_reg <= next_in;
                    case (next_in)
                        snv_pkg::OP_STATUS_READ:  state_reg <= snv_pkg::SNV_SREAD;
                        snv_pkg::OP_STATUS_WRITE: state_reg <= snv_pkg::SNV_SWRITE;
                        snv_pkg::OP_MEM_READ,
                        snv_pkg::OP_MEM_WRITE:    state_reg <= snv_pkg::SNV_ADDR;
                        snv_pkg::OP_IDENT_READ:   state_reg <= snv_pkg::SNV_IDENT;
                        default:                  state_reg <= snv_pkg::SNV_IDLE;
                    endcase
                end
                snv_pkg::SNV_ADDR: begin
                    abyte_reg <= abyte_reg + 2'h1;
                    if (abyte_reg + 2'h1 == snv_pkg::ADDR_BYTES) begin
                        state_reg <= (op_reg == snv_pkg::OP_MEM_READ) ?
                                     snv_pkg::SNV_MREAD : snv_pkg::SNV_MWRITE;
                    end
                end
                snv_pkg::SNV_SWRITE: state_reg <= snv_pkg::SNV_IDLE; // One byte only
                default:             state_reg <= state_reg;
            endcase
        end
    end

    // ==========================================
    // Address pointer, wraps naturally at 11 bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_reg <= snv_pkg::ADDR_ZERO;
        end else if (byte_done && state_reg == snv_pkg::SNV_ADDR) begin
            addr_reg <= {addr_reg[2:0], next_in};
        end else if (byte_done && (state_reg == snv_pkg::SNV_MREAD ||
                                   state_reg == snv_pkg::SNV_MWRITE)) begin
            addr_reg <= addr_reg + 11'h001;
        end
    end

    // ==========================================
    // Array write port
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_we_reg <= 1'b0;
            mem_wd_reg <= 8'h00;
            mem_wa_reg <= snv_pkg::ADDR_ZERO;
        end else begin
            mem_we_reg <= byte_done && state_reg == snv_pkg::SNV_MWRITE && mem_ok;
            mem_wd_reg <= next_in;
            mem_wa_reg <= addr_reg;
        end
    end

    // ==========================================
    // Status nonvolatile bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_nv_reg <= snv_pkg::ST_RESET;
        end else if (byte_done && state_reg == snv_pkg::SNV_SWRITE && stat_ok) begin
            stat_nv_reg <= next_in & snv_pkg::ST_NV_MASK;
        end
    end

    // ==========================================
    // Write latch and write-command memory
    always_ff @(posedge mclk) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
            wr_cmd_reg         <= 1'b0;
        end else if (cs_rise) begin
            // Unrecognised command leaves latch alone
            if (wr_cmd_reg) begin
                write_enable_latch <= 1'b0;
            end
            wr_cmd_reg <= 1'b0;
        end else if (byte_done && state_reg == snv_pkg::SNV_OPCODE) begin
            if (next_in == snv_pkg::OP_LATCH_SET) begin
                write_enable_latch <= 1'b1;
            end else if (next_in == snv_pkg::OP_LATCH_CLEAR) begin
                write_enable_latch <= 1'b0;
            end
            wr_cmd_reg <= (next_in == snv_pkg::OP_STATUS_WRITE) ||
                          (next_in == snv_pkg::OP_MEM_WRITE);
        end
    end

    // ==========================================
    // Output shifter, changes on falling edges
    wire rd_state = state_reg == snv_pkg::SNV_SREAD || state_reg == snv_pkg::SNV_MREAD ||
                    state_reg == snv_pkg::SNV_IDENT;
    wire [7:0] load_byte = (state_reg == snv_pkg::SNV_SREAD) ? status_byte : mem_rd; // Reload source
    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            shout_reg <= 8'h00;
            idc_reg   <= 5'h00;
            sdo       <= 1'b0;
        end else if (sck_dn && rd_state) begin
            case (state_reg)
                snv_pkg::SNV_SREAD,
                snv_pkg::SNV_MREAD: begin
                    // Byte boundary reloads status again, or array data one mclk after pointer moves
                    if (bit_reg == 3'h0) begin
                        sdo       <= load_byte[7];
                        shout_reg <= {load_byte[6:0], 1'b0};
                    end else begin
                        sdo       <= shout_reg[7];
                        shout_reg <= {shout_reg[6:0], 1'b0};
                    end
                end
                default: begin
                    sdo <= snv_pkg::ID_WORD[~idc_reg];
                    if (idc_reg != snv_pkg::ID_LAST) begin
                        idc_reg <= idc_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    // Drive only for reads, selected, not held
    always_ff @(posedge mclk) begin
        if (rst) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= rd_state & live & ~byte_hold_gap;
        end
    end
    // Output only after first falling edge of the data phase
    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            byte_hold_gap <= 1'b1;
        end else if (sck_dn && rd_state) begin
            byte_hold_gap <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    a_partial_opcode: assert property (@(posedge mclk) disable iff (rst)
        (cs_rise && $past(state_reg) == snv_pkg::SNV_OPCODE && !$past(wr_cmd_reg))
        |=> write_enable_latch == $past(write_enable_latch))
        else $error("partial op-code changed latch");
    a_latch_set: assert property (@(posedge mclk) disable iff (rst)
        (byte_done && state_reg == snv_pkg::SNV_OPCODE && next_in == snv_pkg::OP_LATCH_SET && !cs_rise)
        |=> write_enable_latch)
        else $error("latch not set");
    a_write_gated: assert property (@(posedge mclk) disable iff (rst)
        mem_we_reg |-> $past(write_enable_latch) && !$past(prot_hit))
        else $error("array write while protected");
    a_status_bits: assert property (@(posedge mclk) disable iff (rst)
        status_byte[0] == 1'b0 && status_byte[1] == write_enable_latch)
        else $error("status low bits wrong");
    a_latch_cleared: assert property (@(posedge mclk) disable iff (rst)
        (cs_rise && wr_cmd_reg) |=> !write_enable_latch)
        else $error("latch survived write end");
    a_quarter_range: assert property (@(posedge mclk) disable iff (rst)
        (stat_nv_reg[3:2] == 2'h1) |-> prot_hit == (addr_reg[10:9] == 2'h3))
        else $error("quarter protect wrong");
    a_deselect_float: assert property (@(posedge mclk) disable iff (rst)
        (!sel [*2]) |-> !sdo_oe)
        else $error("output driven when deselected");
    a_hold_float: assert property (@(posedge mclk) disable iff (rst)
        hold_act_reg |=> !sdo_oe)
        else $error("output driven in hold");
    a_status_guard: assert property (@(posedge mclk) disable iff (rst)
        (stat_nv_reg != $past(stat_nv_reg)) |-> $past(stat_ok))
        else $error("status written while protected");
    c_array_write: cover property (@(posedge mclk) mem_we_reg);
    c_status_read: cover property (@(posedge mclk) state_reg == snv_pkg::SNV_SREAD && sck_dn);
    c_ident_done: cover property (@(posedge mclk) idc_reg == snv_pkg::ID_LAST);
    c_hold_seen: cover property (@(posedge mclk) hold_exit);
endmodule // snv_core

// file: dv/snv_host.sv
// ==========================================
// Host side model: mode 0 serial master
module snv_host (
    input  wire logic mclk,     // System clock, paces the host
    input  wire logic sdo_wire, // Resolved serial out line
    output logic      cs_n,     // Chip select, active low
    output logic      sck,      // Serial clock, still between frames
    output logic      sdi,      // Serial data toward device
    output logic      hold_n    // Hold request, active low
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Idle levels at time zero
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        sdi    = 1'b0;
        hold_n = 1'b1;
    end

    // Step n clocks, then drive just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Open a frame; clock stays low until first bit
    task automatic frame_open();
        cs_n = 1'b0;
        tick(2);
    endtask

    // Close a frame; released data line shows inverse, not last value
    task automatic frame_close(input int pre);
        tick(pre);
        cs_n = 1'b1;
        sdi  = ~sdi;
        tick(6);
    endtask

    // Send top n bits of tx; sample line late in high phase for margin
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sdi = tx[i];
            tick(4);
            sck = 1'b1;
            tick(4);
            rx  = {rx[6:0], sdo_wire};
            sck = 1'b0;
        end
    endtask

    // Enter hold at low clock, then wiggle clock and data to be ignored
    task automatic hold_on();
        tick(4); // Last falling edge must land before the pause
        hold_n = 1'b0;
        tick(4);
        sck = 1'b1;
        sdi = ~sdi;
        tick(4);
        sck = 1'b0;
        tick(4);
    endtask

    // Leave hold at the same clock level as entry
    task automatic hold_off();
        hold_n = 1'b1;
        tick(4);
    endtask
endmodule // snv_host

// file: dv/tb.sv
// ==========================================
// Self-checking bench for the command logic
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;     // 10 MHz system clock
    logic rst;      // Synchronous reset
    logic wp_n;     // Write-protect pin, held per frame
    logic cs_n;     // From host model
    logic sck;      // From host model
    logic sdi;      // From host model
    logic hold_n;   // From host model
    logic sdo;      // Device serial out
    logic sdo_oe;   // Device output enable
    logic latch;    // Write latch state
    logic sdo_wire; // Line as the host sees it
    int   n_errors; // Mismatch count
    int   n_tests;  // Comparison count

    // Floating line when not driven
    assign sdo_wire = sdo_oe ? sdo : 1'bz;

    // ==========================================
    // Clock, reset, instances
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    snv_core i_snv_core (
        .mclk               (mclk),
        .rst                (rst),
        .cs_n               (cs_n),
        .sck                (sck),
        .sdi                (sdi),
        .hold_n             (hold_n),
        .wp_n               (wp_n),
        .sdo                (sdo),
        .sdo_oe             (sdo_oe),
        .write_enable_latch (latch)
    );
    snv_host i_snv_host (.mclk(mclk), .sdo_wire(sdo_wire), .cs_n(cs_n), .sck(sck), .sdi(sdi), .hold_n(hold_n));

    // ==========================================
    // Checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // Frame helpers
    task automatic op(input logic [7:0] code);
        logic [7:0] r;
        i_snv_host.frame_open();
        i_snv_host.bits(code, 8, r);
        i_snv_host.frame_close(4);
    endtask

    // Status write, latch set first
    task automatic stat_wr(input logic [7:0] v, input bit en);
        logic [7:0] r;
        if (en) op(snv_pkg::OP_LATCH_SET);
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_STATUS_WRITE, 8, r);
        i_snv_host.bits(v, 8, r);
        i_snv_host.frame_close(4);
    endtask

    task automatic stat_rd(output logic [7:0] v);
        logic [7:0] r;
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_STATUS_READ, 8, r);
        i_snv_host.bits(8'h00, 8, v);
        i_snv_host.frame_close(4);
    endtask

    // Two-byte memory access; wr selects write or read
    task automatic mem2(input bit wr, input logic [15:0] a, inout logic [7:0] d0, inout logic [7:0] d1,
                        input bit en);
        logic [7:0] r;
        if (wr && en) op(snv_pkg::OP_LATCH_SET);
        i_snv_host.frame_open();
        i_snv_host.bits(wr ? snv_pkg::OP_MEM_WRITE : snv_pkg::OP_MEM_READ, 8, r);
        i_snv_host.bits(a[15:8], 8, r);
        i_snv_host.bits(a[7:0], 8, r);
        i_snv_host.bits(d0, 8, r);
        if (!wr) d0 = r;
        i_snv_host.bits(d1, 8, r);
        if (!wr) d1 = r;
        i_snv_host.frame_close(4);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_latch();
        logic [7:0] r;
        chk(latch, 1'b0, "latch after reset");
        chk(sdo_oe, 1'b0, "deselected drive");
        op(snv_pkg::OP_LATCH_SET);
        chk(latch, 1'b1, "latch set");
        op(snv_pkg::OP_LATCH_CLEAR);
        chk(latch, 1'b0, "latch clear");
        // Partial clear code with latch set must leave it set
        op(snv_pkg::OP_LATCH_SET);
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_LATCH_CLEAR, 7, r);
        i_snv_host.frame_close(4);
        chk(latch, 1'b1, "partial opcode");
        // Deselect while held must abort, latch untouched
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_LATCH_CLEAR, 4, r);
        i_snv_host.hold_on();
        i_snv_host.frame_close(0);
        i_snv_host.hold_off();
        chk(latch, 1'b1, "abort in hold");
        op(snv_pkg::OP_LATCH_CLEAR);
        chk(latch, 1'b0, "latch clear again");
    endtask

    task automatic t_status();
        logic [7:0] a;
        logic [7:0] b;
        stat_rd(a);
        chk(a, snv_pkg::ST_RESET, "status reset");
        stat_wr(8'hFF, 1);
        chk(latch, 1'b0, "latch after status write");
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_STATUS_READ, 8, a);
        i_snv_host.bits(8'h00, 8, a);
        i_snv_host.bits(8'hFF, 8, b);
        i_snv_host.frame_close(4);
        chk(a, 8'hFC, "status write");
        chk(b, 8'hFC, "status repeat");
        wp_n = 1'b0;
        stat_wr(8'h00, 1);
        stat_rd(a);
        chk(a, 8'hFC, "pin blocks status");
        wp_n = 1'b1;
        stat_wr(8'h00, 0);
        stat_rd(a);
        chk(a, 8'hFC, "no latch status");
        stat_wr(8'h00, 1);
        stat_rd(a);
        chk(a, 8'h00, "pin high allows");
    endtask

    task automatic t_mem();
        logic [7:0] a;
        logic [7:0] b;
        a = 8'hA5;
        b = 8'h3C;
        mem2(1, 16'hF7FF, a, b, 1);
        chk(latch, 1'b0, "latch after write");
        mem2(0, 16'h07FF, a, b, 0);
        chk({a, b}, 16'hA53C, "wrap write read");
        a = 8'h11;
        b = 8'h22;
        mem2(1, 16'h0010, a, b, 1);
        a = 8'h66;
        b = 8'h77;
        mem2(1, 16'h0010, a, b, 0);
        mem2(0, 16'h0010, a, b, 0);
        chk({a, b}, 16'h1122, "no latch write");
    endtask

    // Each protect setting against both sides of both boundaries
    task automatic t_protect();
        logic [10:0] la[4];
        logic [10:0] base;
        logic [7:0]  ex[4];
        logic [7:0]  v;
        logic [7:0]  r[4];
        la = '{11'h3FF, 11'h400, 11'h5FF, 11'h600};
        for (int bp = 0; bp < 4; bp++) begin
            base = (bp == 1) ? snv_pkg::QUART_BASE : (bp == 2) ? snv_pkg::HALF_BASE : snv_pkg::ADDR_ZERO;
            stat_wr({4'h0, 2'(bp), 2'b00}, 1);
            v    = 8'hC0 + 8'(bp);
            r[0] = v;
            r[1] = v;
            mem2(1, {5'h00, la[0]}, r[0], r[1], 1);
            mem2(1, {5'h00, la[2]}, r[0], r[1], 1);
            for (int k = 0; k < 4; k++) begin
                if (bp == 0 || la[k] < base) ex[k] = v;
            end
            mem2(0, {5'h00, la[0]}, r[0], r[1], 0);
            mem2(0, {5'h00, la[2]}, r[2], r[3], 0);
            for (int k = 0; k < 4; k++) begin
                chk(r[k], ex[k], "block protect");
            end
        end
        stat_wr(8'h00, 1);
    endtask

    task automatic t_ident();
        logic [7:0] r;
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_IDENT_READ, 8, r);
        for (int k = 3; k >= 0; k--) begin
            i_snv_host.bits(8'h00, 8, r);
            chk(r, snv_pkg::ID_WORD[8*k +: 8], "identity byte");
        end
        i_snv_host.bits(8'h00, 8, r);
        chk(r, {8{snv_pkg::ID_WORD[0]}}, "identity tail");
        i_snv_host.frame_close(4);
        chk(sdo_oe, 1'b0, "float after frame");
    endtask

    // Pause a status read mid-byte; byte must resume intact
    task automatic t_hold();
        logic [7:0] a;
        logic [7:0] b;
        stat_wr(8'hB0, 1);
        i_snv_host.frame_open();
        i_snv_host.bits(snv_pkg::OP_STATUS_READ, 8, a);
        i_snv_host.bits(8'h00, 4, a);
        i_snv_host.hold_on();
        chk(sdo_oe, 1'b0, "float in hold");
        i_snv_host.hold_off();
        i_snv_host.bits(8'h00, 4, b);
        i_snv_host.frame_close(4);
        chk({a[3:0], b[3:0]}, 8'hB0, "resume after hold");
        stat_wr(8'h00, 1);
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        n_errors = 0;
        n_tests  = 0;
        rst      = 1'b1;
        wp_n     = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        i_snv_host.tick(3);
        t_latch();
        t_status();
        t_mem();
        t_protect();
        t_ident();
        t_hold();
        tally_and_finish();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
